/* verilog/io_line_controller_regs.sv */
// Register block and pad control of the 32-line parallel I/O controller.
`timescale 1ns/10ps
module io_line_controller_regs
   import io_line_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   // Pads
   input wire logic [LINE_W-1:0] line_bits_i,
   output logic [LINE_W-1:0] line_bits_o,
   output logic [LINE_W-1:0] line_bits_oe_o,
   output logic [LINE_W-1:0] pullup_en_o,
   // Peripheral multiplexer and interrupt
   output logic [LINE_W-1:0] periph_b_sel_o,
   output logic irq_o
);

   // ***************************************************************
   // Decoding
   // ***************************************************************
   function automatic logic hit(input logic strobe,
                                input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] ofs);
      hit = strobe && (addr == ofs);
   endfunction

   function automatic logic [LINE_W-1:0] word_if(input logic sel,
                                                 input logic [DATA_W-1:0] w);
      word_if = sel ? w : ZERO_WORD;
   endfunction

   bus_req_type req;
   top_state_type state;
   top_state_type next_state;
   bank_cmd_type bank_cmd [NUM_BANKS];
   logic [LINE_W-1:0] bank_bits [NUM_BANKS];
   logic [LINE_W-1:0] line_change;
   logic [LINE_W-1:0] irq_mask;
   logic [LINE_W-1:0] open_drain;
   logic [LINE_W-1:0] pullup_off;
   logic [LINE_W-1:0] periph_b;
   logic [LINE_W-1:0] out_write;

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
   assign irq_mask = bank_bits[BANK_IRQ];
   assign open_drain = bank_bits[BANK_OPEN_DRAIN];
   assign pullup_off = bank_bits[BANK_PULLUP_OFF];
   assign periph_b = bank_bits[BANK_PERIPH_B];
   assign out_write = bank_bits[BANK_OUT_WRITE];

   // ***************************************************************
   // Set and clear commands for the per-line banks
   // ***************************************************************
   always_comb begin
      bank_cmd[BANK_IRQ].set =
         word_if(hit(req.wr, req.addr, IRQ_ENABLE_OFS), req.wdata);
      bank_cmd[BANK_IRQ].clr =
         word_if(hit(req.wr, req.addr, IRQ_DISABLE_OFS), req.wdata);
      bank_cmd[BANK_OPEN_DRAIN].set =
         word_if(hit(req.wr, req.addr, OPEN_DRAIN_ENABLE_OFS),
                 req.wdata);
      bank_cmd[BANK_OPEN_DRAIN].clr =
         word_if(hit(req.wr, req.addr, OPEN_DRAIN_DISABLE_OFS),
                 req.wdata);
      // The pull-up bank stores the disabled sense, so reset leaves
      // every pull-up switched on.
      bank_cmd[BANK_PULLUP_OFF].set =
         word_if(hit(req.wr, req.addr, PULLUP_DISABLE_OFS), req.wdata);
      bank_cmd[BANK_PULLUP_OFF].clr =
         word_if(hit(req.wr, req.addr, PULLUP_ENABLE_OFS), req.wdata);
      bank_cmd[BANK_PERIPH_B].set =
         word_if(hit(req.wr, req.addr, PERIPH_B_SELECT_OFS),
                 req.wdata);
      bank_cmd[BANK_PERIPH_B].clr =
         word_if(hit(req.wr, req.addr, PERIPH_A_SELECT_OFS),
                 req.wdata);
      bank_cmd[BANK_OUT_WRITE].set =
         word_if(hit(req.wr, req.addr, OUT_WRITE_ENABLE_OFS),
                 req.wdata);
      bank_cmd[BANK_OUT_WRITE].clr =
         word_if(hit(req.wr, req.addr, OUT_WRITE_DISABLE_OFS),
                 req.wdata);
   end

   // ***************************************************************
   // Bank instances
   // ***************************************************************
   generate
      for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
         line_bit_bank u_bank (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .cmd_i(bank_cmd[b]),
            .bits_o(bank_bits[b])
         );
      end
   endgenerate

   // ***************************************************************
   // Input change detection
   // ***************************************************************
   line_change_detect u_change (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .line_i(line_bits_i),
      .change_o(line_change)
   );

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      logic status_clr;
      logic data_wr;
      status_clr = 1'b0;
      data_wr = 1'b0;
      next_state = state;

      // Output data only moves on lines that are open for writing.
      data_wr = hit(req.wr, req.addr, OUT_DATA_OFS);
      if (data_wr) begin
         next_state.out_data = (state.out_data & ~out_write) |
                               (req.wdata & out_write);
      end

      // Clear on read, but a change in the same cycle survives so no
      // event is lost between the read and the next one.
      status_clr = hit(req.rd, req.addr, IRQ_STATUS_OFS);
      next_state.status = (status_clr ? ZERO_WORD : state.status) |
                          line_change;

      // Read data stand for one cycle only and are zero otherwise.
      next_state.rdata = ZERO_WORD;
      if (req.rd) begin
         case (req.addr)
            OUT_DATA_OFS: begin
               next_state.rdata = state.out_data;
            end
            LINE_LEVEL_OFS: begin
               next_state.rdata = line_bits_i;
            end
            IRQ_MASK_OFS: begin
               next_state.rdata = irq_mask;
            end
            IRQ_STATUS_OFS: begin
               next_state.rdata = state.status;
            end
            OPEN_DRAIN_STATE_OFS: begin
               next_state.rdata = open_drain;
            end
            PULLUP_STATE_OFS: begin
               next_state.rdata = pullup_off;
            end
            PERIPH_SELECT_STATE_OFS: begin
               next_state.rdata = periph_b;
            end
            OUT_WRITE_STATE_OFS: begin
               next_state.rdata = out_write;
            end
            default: begin
               next_state.rdata = ZERO_WORD;
            end
         endcase
      end

      // The interrupt follows the mask two cycles after a mask write.
      next_state.irq = |(next_state.status & irq_mask);

      // Pad drivers.
      next_state.pad_out = next_state.out_data;
      for (int i = 0; i < LINE_W; i++) begin
         if (open_drain[i]) begin
            // Only a low is driven; a high releases the pin.
            next_state.pad_oe[i] = ~next_state.out_data[i];
         end else begin
            next_state.pad_oe[i] = 1'b1;
         end
      end
      next_state.pullup_en = ~pullup_off;
      next_state.periph_b = periph_b;
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state <= '{out_data: OUT_DATA_RESET,
                    status: ZERO_WORD,
                    rdata: ZERO_WORD,
                    irq: 1'b0,
                    pad_out: OUT_DATA_RESET,
                    pad_oe: ONES_WORD,
                    pullup_en: ONES_WORD,
                    periph_b: ZERO_WORD};
      end else begin
         state <= next_state;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign rdata_o = state.rdata;
   assign line_bits_o = state.pad_out;
   assign line_bits_oe_o = state.pad_oe;
   assign pullup_en_o = state.pullup_en;
   assign periph_b_sel_o = state.periph_b;
   assign irq_o = state.irq;

endmodule

/* verilog/io_line_pkg.sv */
// Package with register map, reset values and carriers of the line block.
package io_line_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int LINE_W = 32;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ***************************************************************
   // Register byte offsets
   // ***************************************************************
   localparam logic [7:0] OUT_DATA_OFS = 8'h38;
   localparam logic [7:0] LINE_LEVEL_OFS = 8'h3c;
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h40;
   localparam logic [7:0] IRQ_DISABLE_OFS = 8'h44;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h48;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h4c;
   localparam logic [7:0] OPEN_DRAIN_ENABLE_OFS = 8'h50;
   localparam logic [7:0] OPEN_DRAIN_DISABLE_OFS = 8'h54;
   localparam logic [7:0] OPEN_DRAIN_STATE_OFS = 8'h58;
   localparam logic [7:0] PULLUP_DISABLE_OFS = 8'h60;
   localparam logic [7:0] PULLUP_ENABLE_OFS = 8'h64;
   localparam logic [7:0] PULLUP_STATE_OFS = 8'h68;
   localparam logic [7:0] PERIPH_A_SELECT_OFS = 8'h70;
   localparam logic [7:0] PERIPH_B_SELECT_OFS = 8'h74;
   localparam logic [7:0] PERIPH_SELECT_STATE_OFS = 8'h78;
   localparam logic [7:0] OUT_WRITE_ENABLE_OFS = 8'ha0;
   localparam logic [7:0] OUT_WRITE_DISABLE_OFS = 8'ha4;
   localparam logic [7:0] OUT_WRITE_STATE_OFS = 8'ha8;

   // ***************************************************************
   // Per-line state banks and reset values
   // ***************************************************************
   localparam int BANK_IRQ = 0;
   localparam int BANK_OPEN_DRAIN = 1;
   localparam int BANK_PULLUP_OFF = 2;
   localparam int BANK_PERIPH_B = 3;
   localparam int BANK_OUT_WRITE = 4;
   localparam int NUM_BANKS = 5;
   localparam logic [31:0] BANK_RESET = 32'h0000_0000;
   localparam logic [31:0] OUT_DATA_RESET = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] ONES_WORD = 32'hffff_ffff;

   // ***************************************************************
   // Carriers and state records
   // ***************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef struct packed {
      logic [LINE_W-1:0] set;
      logic [LINE_W-1:0] clr;
   } bank_cmd_type;

   typedef struct packed {
      logic [LINE_W-1:0] bits;
   } bank_state_type;

   typedef struct packed {
      logic [LINE_W-1:0] prev;
      logic primed;
      logic [LINE_W-1:0] change;
   } change_state_type;

   typedef struct packed {
      logic [LINE_W-1:0] out_data;
      logic [LINE_W-1:0] status;
      logic [DATA_W-1:0] rdata;
      logic irq;
      logic [LINE_W-1:0] pad_out;
      logic [LINE_W-1:0] pad_oe;
      logic [LINE_W-1:0] pullup_en;
      logic [LINE_W-1:0] periph_b;
   } top_state_type;

endpackage

/* verilog/line_bit_bank.sv */
// Per-line state bits that are set and cleared by separate write strobes.
`timescale 1ns/10ps
module line_bit_bank
   import io_line_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Commands
   input wire bank_cmd_type cmd_i,
   // State
   output logic [LINE_W-1:0] bits_o
);

   bank_state_type state;
   bank_state_type next_state;

   // ***************************************************************
   // Update
   // ***************************************************************
   // Set and clear come from different addresses, so they never meet.
   always_comb begin
      next_state = state;
      next_state.bits = (state.bits | cmd_i.set) & ~cmd_i.clr;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state <= '{bits: BANK_RESET};
      end else begin
         state <= next_state;
      end
   end

   assign bits_o = state.bits;

endmodule

/* verilog/line_change_detect.sv */
// Input change detector over all lines.
`timescale 1ns/10ps
module line_change_detect
   import io_line_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Lines
   input wire logic [LINE_W-1:0] line_i,
   output logic [LINE_W-1:0] change_o
);

   change_state_type state;
   change_state_type next_state;

   // ***************************************************************
   // Detection
   // ***************************************************************
   // The first sample after reset only primes the history, so the
   // pad levels found at reset are not reported as changes.
   always_comb begin
      next_state = state;
      next_state.prev = line_i;
      next_state.primed = 1'b1;
      for (int i = 0; i < LINE_W; i++) begin
         next_state.change[i] = state.primed & (line_i[i] ^ state.prev[i]);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign change_o = state.change;

endmodule

/* tb/io_line_controller_regs_properties.sv */
// Concurrent checks on the ports of the line controller.
`timescale 1ns/10ps
module io_line_controller_regs_properties
   import io_line_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   // Pads and interrupt
   input wire logic [LINE_W-1:0] line_bits_o,
   input wire logic [LINE_W-1:0] line_bits_oe_o,
   input wire logic [LINE_W-1:0] pullup_en_o,
   input wire logic [LINE_W-1:0] periph_b_sel_o,
   input wire logic irq_o
);
   // ***************************************************************
   // Properties
   // ***************************************************************
   // Outputs are registered, so a write shows two edges after its strobe.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_pu_off;
      wr_i && addr_i == PULLUP_DISABLE_OFS
      |-> ##2 (pullup_en_o & $past(wdata_i, 2)) == ZERO_WORD;
   endproperty
   a_pu_off: assert property (p_pu_off) else $error("pull-up left on");
   property p_pu_on;
      wr_i && addr_i == PULLUP_ENABLE_OFS
      |-> ##2 (~pullup_en_o & $past(wdata_i, 2)) == ZERO_WORD;
   endproperty
   a_pu_on: assert property (p_pu_on) else $error("pull-up left off");
   property p_sel_b;
      wr_i && addr_i == PERIPH_B_SELECT_OFS
      |-> ##2 (~periph_b_sel_o & $past(wdata_i, 2)) == ZERO_WORD;
   endproperty
   a_sel_b: assert property (p_sel_b) else $error("line not on B");
   property p_sel_a;
      wr_i && addr_i == PERIPH_A_SELECT_OFS
      |-> ##2 (periph_b_sel_o & $past(wdata_i, 2)) == ZERO_WORD;
   endproperty
   a_sel_a: assert property (p_sel_a) else $error("line not on A");
   property p_od_off;
      wr_i && addr_i == OPEN_DRAIN_DISABLE_OFS
      |-> ##2 (~line_bits_oe_o & $past(wdata_i, 2)) == ZERO_WORD;
   endproperty
   a_od_off: assert property (p_od_off) else $error("push-pull off");
   property p_od_on;
      wr_i && addr_i == OPEN_DRAIN_ENABLE_OFS
      |-> ##2 ((line_bits_oe_o ^ ~line_bits_o)
               & $past(wdata_i, 2)) == ZERO_WORD;
   endproperty
   a_od_on: assert property (p_od_on) else $error("open-drain wrong");
   property p_release_high;
      (~line_bits_oe_o & ~line_bits_o) == ZERO_WORD;
   endproperty
   a_release_high: assert property (p_release_high)
      else $error("low released");
   property p_irq_off;
      wr_i && addr_i == IRQ_DISABLE_OFS && wdata_i == ONES_WORD
      |-> ##3 !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("irq while masked");
   c_irq: cover property ($rose(irq_o));
   c_od: cover property (wr_i && addr_i == OPEN_DRAIN_ENABLE_OFS);
   c_mask: cover property (wr_i && addr_i == IRQ_DISABLE_OFS);
endmodule
bind io_line_controller_regs io_line_controller_regs_properties u_props (
   .core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .line_bits_o(line_bits_o),
   .line_bits_oe_o(line_bits_oe_o),
   .pullup_en_o(pullup_en_o),
   .periph_b_sel_o(periph_b_sel_o),
   .irq_o(irq_o)
);

/* tb/io_line_controller_regs_tb_top.sv */
// Self-checking bench of the line controller register block.
`timescale 1ns/10ps
module io_line_controller_regs_tb_top
   import io_line_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 8'h00;
   logic [DATA_W-1:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [LINE_W-1:0] line_bits_i = 32'h0000_0000;
   logic [DATA_W-1:0] rdata_o;
   logic [LINE_W-1:0] line_bits_o;
   logic [LINE_W-1:0] line_bits_oe_o;
   logic [LINE_W-1:0] pullup_en_o;
   logic [LINE_W-1:0] periph_b_sel_o;
   logic irq_o;
   int error_cnt = 0;
   int cmp_count = 0;

   io_line_controller_regs u_dut (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .line_bits_i(line_bits_i),
      .line_bits_o(line_bits_o),
      .line_bits_oe_o(line_bits_oe_o),
      .pullup_en_o(pullup_en_o),
      .periph_b_sel_o(periph_b_sel_o),
      .irq_o(irq_o)
   );

   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   // ***************************************************************
   // Bus and compare tasks
   // ***************************************************************
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // The interrupt is a single bit, so it gets a compare of its own.
   task automatic chk_irq(input logic exp);
      cmp_count++;
      if (irq_o !== exp) begin
         error_cnt++;
         $display("MISMATCH irq expected %b seen %b", exp, irq_o);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      chk(what, exp, rdata_o);
   endtask

   task automatic settle;
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic test_reset;
      rd_chk("mask", IRQ_MASK_OFS, ZERO_WORD);
      rd_chk("status", IRQ_STATUS_OFS, ZERO_WORD);
      rd_chk("pullup", PULLUP_STATE_OFS, ZERO_WORD);
      rd_chk("unmapped", 8'hfc, ZERO_WORD);
      rd_chk("write-only", IRQ_DISABLE_OFS, ZERO_WORD);
      wr(OPEN_DRAIN_STATE_OFS, ONES_WORD);
      rd_chk("od state ro", OPEN_DRAIN_STATE_OFS, ZERO_WORD);
      chk("pullup out", ONES_WORD, pullup_en_o);
      chk("oe out", ONES_WORD, line_bits_oe_o);
      chk("periph out", ZERO_WORD, periph_b_sel_o);
      $display("test reset done");
   endtask

   // Each set/clear pair with its status: set, no-op, partial clear.
   task automatic test_pairs;
      logic [7:0] s[5] = '{IRQ_ENABLE_OFS, OPEN_DRAIN_ENABLE_OFS,
         PULLUP_DISABLE_OFS, PERIPH_B_SELECT_OFS, OUT_WRITE_ENABLE_OFS};
      logic [7:0] c[5] = '{IRQ_DISABLE_OFS, OPEN_DRAIN_DISABLE_OFS,
         PULLUP_ENABLE_OFS, PERIPH_A_SELECT_OFS, OUT_WRITE_DISABLE_OFS};
      logic [7:0] st[5] = '{IRQ_MASK_OFS, OPEN_DRAIN_STATE_OFS,
         PULLUP_STATE_OFS, PERIPH_SELECT_STATE_OFS, OUT_WRITE_STATE_OFS};
      for (int i = 0; i < 5; i++) begin
         wr(s[i], 32'h8000_00f1);
         rd_chk("set", st[i], 32'h8000_00f1);
         wr(s[i], ZERO_WORD);
         wr(c[i], 32'h0000_0031);
         rd_chk("clear", st[i], 32'h8000_00c0);
         wr(c[i], ONES_WORD);
         rd_chk("all clear", st[i], ZERO_WORD);
      end
      $display("test pairs done");
   endtask

   task automatic test_pads;
      wr(PULLUP_DISABLE_OFS, 32'h0000_ff00);
      wr(PERIPH_B_SELECT_OFS, 32'h00ff_0000);
      wr(OUT_WRITE_ENABLE_OFS, 32'h0000_ffff);
      wr(OUT_DATA_OFS, ONES_WORD);
      wr(OUT_WRITE_DISABLE_OFS, 32'h0000_00f0);
      wr(OUT_DATA_OFS, ZERO_WORD);
      wr(OPEN_DRAIN_ENABLE_OFS, 32'h0000_00ff);
      settle;
      chk("pad data", 32'h0000_00f0, line_bits_o);
      chk("pad oe", 32'hffff_ff0f, line_bits_oe_o);
      chk("pullup out", 32'hffff_00ff, pullup_en_o);
      chk("periph out", 32'h00ff_0000, periph_b_sel_o);
      rd_chk("out data", OUT_DATA_OFS, 32'h0000_00f0);
      wr(OPEN_DRAIN_DISABLE_OFS, ONES_WORD);
      wr(PULLUP_ENABLE_OFS, ONES_WORD);
      wr(PERIPH_A_SELECT_OFS, ONES_WORD);
      settle;
      chk("pad oe", ONES_WORD, line_bits_oe_o);
      chk("pullup out", ONES_WORD, pullup_en_o);
      chk("periph out", ZERO_WORD, periph_b_sel_o);
      $display("test pads done");
   endtask

   task automatic test_irq;
      wr(IRQ_ENABLE_OFS, 32'h0000_0005);
      line_bits_i <= 32'h0000_0003;
      settle;
      chk_irq(1'b1);
      rd_chk("status", IRQ_STATUS_OFS, 32'h0000_0003);
      rd_chk("status again", IRQ_STATUS_OFS, ZERO_WORD);
      chk_irq(1'b0);
      // Pad levels move right after a rising edge, like every input.
      @(posedge core_clk_i);
      line_bits_i <= 32'h0000_0002;
      settle;
      chk_irq(1'b1);
      rd_chk("levels", LINE_LEVEL_OFS, 32'h0000_0002);
      wr(IRQ_DISABLE_OFS, ONES_WORD);
      settle;
      chk_irq(1'b0);
      rd_chk("mask", IRQ_MASK_OFS, ZERO_WORD);
      rd_chk("status", IRQ_STATUS_OFS, 32'h0000_0001);
      $display("test irq done");
   endtask

   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      test_reset;
      test_pairs;
      test_pads;
      test_irq;
      final_report;
   end

   // The tests need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge core_clk_i);
      error_cnt++;
      final_report;
   end
endmodule
